// >>> dram_host.sv
// Purpose: Controller driving a 4M x 36 fast page mode memory module.
// Assumes: Single clock ref_clk 40 MHz, rst synchronous active high.
// Notes:   Strobes are active low pins; data bus is three signals.
// How it works
// - Row strobe high means standby, bus released
// - Read: row, then column with write high
// - Early write: column falls with write low
// - Page read: one row, many columns read
// - Page write: one row, many columns written
// - Row-only refresh: row strobe, column high
// - Column-first refresh: column before row falls
// - Power-up: 200 us pause, eight row refreshes
// - Internal counter: eight column-first refreshes instead
// - Random cycles spaced 110 or 130 ns
// - Row strobe low 60/70 ns, under 16K
// - Row precharge 40 or 50 ns
// - Column strobe at least 20 ns after row
// - 2048 refreshes within every 32 ms
// - Eleven-bit row and column multiplexed address
module dram_host
    import dram_pkg::*;
#(
    parameter int INIT_CYC    = `INIT_PAUSE_US * 1000 / `CLK_PERIOD_NS,
    parameter int REFI_CYC    = `REFRESH_MS * 1000000 / `CLK_PERIOD_NS
                                / `REFRESH_ROWS,
    parameter bit USE_CBR     = 1'b0
) (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // Speed grade: 1 selects the slower grade
    input  wire logic                  slow_grade,
    // User request
    input  wire logic                  req_valid,
    input  wire req_t                  req,
    output logic                       req_ready,
    // User read answer
    output logic                       rsp_valid,
    output rsp_t                       rsp,
    // Status
    output logic                       init_done,
    output logic [3:0]                 presence_seen,
    // Module pins, strobes active low
    output logic                       row_strobe_n,
    output logic [`LANES-1:0]          col_strobe_n,
    output logic                       write_n,
    output logic [`ROW_BITS-1:0]       addr,
    output logic [`WORD_BITS-1:0]      dq_out,
    output logic [`WORD_BITS-1:0]      dq_oe,
    input  wire logic [`WORD_BITS-1:0] dq_in,
    // Presence straps from the module
    input  wire logic                  presence_bit_one,
    input  wire logic                  presence_bit_two,
    input  wire logic                  presence_bit_three,
    input  wire logic                  presence_bit_four
);
    localparam int CW = 16;
    // Derived cycle counts per grade
    localparam logic [CW-1:0] RAS_F = CW'(`CYC_UP(`RAS_NS_FAST));
    localparam logic [CW-1:0] RAS_S = CW'(`CYC_UP(`RAS_NS_SLOW));
    localparam logic [CW-1:0] PRE_F = CW'(`CYC_UP(`PRE_NS_FAST));
    localparam logic [CW-1:0] PRE_S = CW'(`CYC_UP(`PRE_NS_SLOW));
    localparam logic [CW-1:0] CYC_F = CW'(`CYC_UP(`CYC_NS_FAST));
    localparam logic [CW-1:0] CYC_S = CW'(`CYC_UP(`CYC_NS_SLOW));
    localparam logic [CW-1:0] RCD   = CW'(`CYC_UP(`RCD_MIN_NS));
    localparam logic [CW-1:0] ACC_F = CW'(`CYC_UP(`ACC_NS_FAST));
    localparam logic [CW-1:0] ACC_S = CW'(`CYC_UP(`ACC_NS_SLOW));
    localparam logic [CW-1:0] CAC_F = CW'(`CYC_UP(`CPA_NS_FAST));
    localparam logic [CW-1:0] CAC_S = CW'(`CYC_UP(`CPA_NS_SLOW));
    localparam logic [CW-1:0] CPRE  = CW'(`CYC_UP(`CPRE_NS));
    // Register stages between the data pins and the kept word
    localparam logic [CW-1:0] CAPT  = CW'(`CAPTURE_STAGES);
    localparam logic [CW-1:0] RASMX = CW'(`RAS_MAX_NS / `CLK_PERIOD_NS);
    localparam int LW = `LANE_BITS;

    // Controller states
    typedef enum logic [3:0] {
        s_pause, s_init_ref, s_idle, s_row, s_col, s_col_hold,
        s_col_pre, s_cbr_col, s_cbr_row, s_precharge
    } state_t;

    state_t             st_q;             // Current state
    logic [31:0]        pause_q;          // Power-up pause count
    logic [3:0]         init_n_q;         // Init refreshes done
    logic [31:0]        refi_q;           // Refresh interval count
    logic               ref_due_q;        // Refresh owed
    logic [CW-1:0]      t_q;              // Phase timer
    logic [CW-1:0]      ras_t_q;          // Time since row fell
    logic [CW-1:0]      cyc_t_q;          // Time since cycle start
    logic [`ROW_BITS-1:0] ref_row_q;      // Row-only refresh counter
    req_t               cur_q;            // Held request
    logic [3:0]         pd_s1_q, pd_s2_q, pd_s3_q; // Strap syncs
    logic [`WORD_BITS-1:0] rd_s1_q, rd_s2_q;       // Read data stages
    logic               cbr_q;            // Column-first or owed refresh in flight

    // Grade-dependent limits
    wire [CW-1:0] ras_min = slow_grade ? RAS_S : RAS_F;
    wire [CW-1:0] pre_min = slow_grade ? PRE_S : PRE_F;
    wire [CW-1:0] cyc_min = slow_grade ? CYC_S : CYC_F;
    wire [CW-1:0] acc_ras = slow_grade ? ACC_S : ACC_F;
    wire [CW-1:0] acc_cas = slow_grade ? CAC_S : CAC_F;
    wire          pend    = ref_due_q;
    wire          near_max = (ras_t_q + acc_cas + CPRE + CAPT) >= RASMX;

    // Presence straps pass three flops, settle when two agree
    always_ff @(posedge ref_clk) begin
        pd_s1_q <= {presence_bit_four, presence_bit_three,
                    presence_bit_two, presence_bit_one};
        pd_s2_q <= pd_s1_q;
        pd_s3_q <= pd_s2_q;
        if (rst) begin
            presence_seen <= 4'h0;
        end else if (pd_s2_q == pd_s3_q) begin
            presence_seen <= pd_s3_q;
        end
    end

    // Read data captured into two stages
    always_ff @(posedge ref_clk) begin
        rd_s1_q <= dq_in;
        rd_s2_q <= rd_s1_q;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            refi_q    <= 32'h0;
            ref_due_q <= 1'b0;
        end else begin
            refi_q <= (refi_q >= 32'(REFI_CYC - 1)) ? 32'h0 : refi_q + 1;
            // Set wins over clear
            if (refi_q >= 32'(REFI_CYC - 1) && init_done)
                ref_due_q <= 1'b1;
            else if (st_q == s_precharge && t_q == 0 && cbr_q)
                ref_due_q <= 1'b0;
        end
    end

    // Cycle timers since row strobe fell and since cycle start
    always_ff @(posedge ref_clk) begin
        if (rst || st_q == s_idle || st_q == s_init_ref) begin
            ras_t_q <= '0;
            cyc_t_q <= '0;
        end else begin
            if (!row_strobe_n && ras_t_q != '1) ras_t_q <= ras_t_q + 1'b1;
            if (cyc_t_q != '1) cyc_t_q <= cyc_t_q + 1'b1;
        end
    end

    // Main sequencer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q         <= s_pause;
            pause_q      <= 32'h0;
            init_n_q     <= 4'h0;
            init_done    <= 1'b0;
            t_q          <= '0;
            ref_row_q    <= '0;
            cur_q        <= '0;
            cbr_q        <= 1'b0;
            req_ready    <= 1'b0;
            rsp_valid    <= 1'b0;
            rsp          <= '0;
            row_strobe_n <= 1'b1;
            col_strobe_n <= '1;
            write_n      <= 1'b1;
            addr         <= '0;
            dq_out       <= '0;
            dq_oe        <= '0;
        end else begin
            rsp_valid <= 1'b0;
            req_ready <= 1'b0;
            if (t_q != 0) t_q <= t_q - 1'b1;
            unique case (st_q)
                s_pause: begin
                    pause_q <= pause_q + 1;
                    if (pause_q >= 32'(INIT_CYC - 1)) st_q <= s_init_ref;
                end
                // eight init refreshes of the chosen kind
                s_init_ref: begin
                    if (init_n_q == 4'(`INIT_REFRESHES)) begin
                        init_done <= 1'b1;
                        st_q      <= s_idle;
                        req_ready <= 1'b1;
                    end else begin
                        init_n_q <= init_n_q + 1'b1;
                        cbr_q    <= USE_CBR;
                        start_refresh(USE_CBR);
                    end
                end
                // standby: bus floats while row strobe high
                s_idle: begin
                    dq_oe <= '0;
                    // Offered ready binds: take before an owed refresh
                    if (req_valid && req_ready) begin
                        cur_q        <= req;
                        addr         <= req.row;
                        row_strobe_n <= 1'b0;
                        t_q          <= RCD - 1'b1;
                        cbr_q        <= 1'b0;
                        if (req.op == op_refresh_row) begin
                            t_q  <= ras_min - 1'b1;
                            st_q <= s_cbr_row;
                        end else if (req.op == op_refresh_cbr) begin
                            row_strobe_n <= 1'b1;
                            cbr_q        <= 1'b1;
                            start_refresh(1'b1);
                        end else begin
                            st_q <= s_row;
                        end
                    end else if (pend) begin
                        cbr_q <= 1'b1;
                        start_refresh(USE_CBR);
                    end else begin
                        req_ready <= 1'b1;
                    end
                end
                // column falls no sooner than 20 ns after row
                s_row: begin
                    if (t_q == 0) st_q <= s_col;
                end
                s_col: begin
                    addr <= {{(`ROW_BITS-`COL_BITS){1'b0}}, cur_q.col};
                    write_n <= (cur_q.op != op_write);
                    if (cur_q.op == op_write) begin
                        // lanes of data plus parity driven
                        dq_out <= cur_q.wdata;
                        for (int l = 0; l < `LANES; l++)
                            dq_oe[l*LW +: LW] <= {LW{cur_q.lanes[l]}};
                    end
                    col_strobe_n <= ~cur_q.lanes;
                    // wait for latest of access limits, plus the
                    // capture stages so the kept word is sampled late
                    t_q <= (((ras_t_q + acc_cas) < acc_ras)
                           ? acc_ras - ras_t_q : acc_cas) + CAPT;
                    st_q <= s_col_hold;
                end
                s_col_hold: begin
                    if (t_q == 0) begin
                        if (cur_q.op == op_read) begin
                            rsp_valid <= 1'b1;
                            rsp       <= '{rdata: rd_s2_q,
                                           col: {{(`ROW_BITS-`COL_BITS){1'b0}},
                                                 cur_q.col}};
                        end
                        col_strobe_n <= '1;
                        write_n      <= 1'b1;
                        dq_oe        <= '0;
                        t_q          <= CPRE - 1'b1;
                        st_q         <= s_col_pre;
                    end
                end
                // page continues while same row and in budget
                s_col_pre: begin
                    if (t_q == 0) begin
                        if (!cur_q.last && !pend && !near_max && req_valid
                            && req.row == cur_q.row
                            && (req.op == cur_q.op)) begin
                            cur_q <= req;
                            st_q  <= s_col;
                            req_ready <= 1'b1;
                        end else begin
                            close_row();
                        end
                    end
                end
                // column strobe low before row falls, write high
                s_cbr_col: begin
                    if (t_q == 0) begin
                        row_strobe_n <= 1'b0;
                        t_q          <= ras_min - 1'b1;
                        st_q         <= s_cbr_row;
                    end
                end
                // row strobe held its least low time
                s_cbr_row: begin
                    if (t_q == 0) begin
                        close_row();
                    end
                end
                s_precharge: begin
                    if (t_q == 0 && cyc_t_q >= cyc_min) begin
                        st_q <= init_done ? s_idle : s_init_ref;
                        if (init_done) req_ready <= 1'b1;
                    end
                end
                default: st_q <= s_idle;
            endcase
        end
    end

    // Begin a refresh of either kind
    task automatic start_refresh(input logic column_first_refresh);
        if (column_first_refresh) begin
            col_strobe_n <= '0;
            write_n      <= 1'b1;
            t_q          <= CPRE - 1'b1;
            st_q         <= s_cbr_col;
        end else begin
            addr         <= ref_row_q;
            ref_row_q    <= ref_row_q + 1'b1;
            row_strobe_n <= 1'b0;
            t_q          <= ras_min - 1'b1;
            st_q         <= s_cbr_row;
        end
    endtask

    // Raise strobes and enter precharge
    task automatic close_row();
        row_strobe_n <= 1'b1;
        col_strobe_n <= '1;
        write_n      <= 1'b1;
        dq_oe        <= '0;
        t_q          <= pre_min - 1'b1;
        st_q         <= s_precharge;
    endtask
endmodule

// >>> dram_map.svh
// Purpose: Constants of the page mode memory controller.
// Assumes: 40 MHz ref_clk, 25 ns period.
// Notes:   Times in their own unit; cycle counts derived from them.
`ifndef DRAM_MAP_SVH
`define DRAM_MAP_SVH
`define CLK_PERIOD_NS    25
`define ROW_BITS         11
`define COL_BITS         11
`define LANES            4
`define LANE_BITS        9
`define WORD_BITS        36
`define INIT_PAUSE_US    200
`define INIT_REFRESHES   8
`define REFRESH_ROWS     2048
`define REFRESH_MS       32
`define CYC_NS_FAST      110
`define CYC_NS_SLOW      130
`define RAS_NS_FAST      60
`define RAS_NS_SLOW      70
`define RAS_MAX_NS       16000
`define PRE_NS_FAST      40
`define PRE_NS_SLOW      50
`define RCD_MIN_NS       20
`define RCD_MAX_NS_FAST  45
`define RCD_MAX_NS_SLOW  50
`define ACC_NS_FAST      60
`define ACC_NS_SLOW      70
`define CAS_NS_FAST      15
`define CAS_NS_SLOW      20
`define CPRE_NS          10
`define CPA_NS_FAST      35
`define CPA_NS_SLOW      40
`define CAPTURE_STAGES   2
`define PD_GROUNDED      1'b0
`define PD_OPEN          1'b1
// Round a least time up to whole cycles; a zero time gives zero
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> dram_pkg.sv
// Purpose: Types for the page mode memory controller.
// Assumes: dram_map.svh holds the numbers.
// Notes:   Request and answer travel as packed structs.
package dram_pkg;
    `include "dram_map.svh"
    // Host operation codes
    typedef enum logic [1:0] {
        op_read, op_write, op_refresh_row, op_refresh_cbr
    } op_t;
    // One request from the user
    typedef struct packed {
        op_t                     op;
        logic [`ROW_BITS-1:0]    row;
        logic [`COL_BITS-1:0]    col;
        logic [`LANES-1:0]       lanes;
        logic                    last;
        logic [`WORD_BITS-1:0]   wdata;
    } req_t;
    // One read answer
    typedef struct packed {
        logic [`WORD_BITS-1:0]   rdata;
        logic [`ROW_BITS-1:0]    col;
    } rsp_t;
endpackage

// >>> dram_module_model.sv
// Purpose: Behavioural page mode memory module for the host bench.
// Assumes: Pins looked at on ref_clk edges; strobes active low.
// Notes:   Released data lines show the inverse of the last word.
module dram_module_model (
    // Clock and speed grade
    input  wire logic        ref_clk,
    input  wire logic        slow_grade,
    // Strobes and address
    input  wire logic        row_strobe_n,
    input  wire logic [3:0]  col_strobe_n,
    input  wire logic        write_n,
    input  wire logic [10:0] addr,
    // Data lines
    input  wire logic [35:0] dq_out,
    input  wire logic [35:0] dq_oe,
    output logic [35:0]      dq_in,
    // Presence straps
    output logic             presence_bit_one,
    output logic             presence_bit_two,
    output logic             presence_bit_three,
    output logic             presence_bit_four
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] mem [logic [21:0]];
    logic [10:0] row_q;           // Open row
    logic        ras_q  = 1'b1;   // Row strobe at last edge
    logic [3:0]  cas_q  = 4'hf;   // Column strobes at last edge
    logic [3:0]  drv_q  = 4'h0;   // Lanes reading out
    int          age_q  = 0;      // Edges since row fell
    logic [35:0] word_q = 36'h0;  // Last word read
    logic [35:0] shown;           // Bus value before access delay
    assign presence_bit_one   = 1'b0;
    assign presence_bit_two   = 1'b1;
    assign presence_bit_three = ~slow_grade;
    assign presence_bit_four  = 1'b1;
    // Strobe edges, row capture and lane access
    always @(posedge ref_clk) begin
        logic [35:0] w;
        w = mem.exists({row_q, addr}) ? mem[{row_q, addr}] : 36'h0;
        ras_q <= row_strobe_n;
        cas_q <= col_strobe_n;
        age_q <= row_strobe_n ? 0 : age_q + 1;
        // row kept only with columns idle
        if (ras_q && !row_strobe_n && &col_strobe_n)
            row_q <= addr;
        for (int l = 0; l < 4; l++) begin
            if (row_strobe_n || col_strobe_n[l])
                drv_q[l] <= 1'b0;
            else if (cas_q[l] && !ras_q && write_n) begin
                drv_q[l] <= 1'b1;
                word_q[9*l +: 9] <= w[9*l +: 9];
            end else if (cas_q[l] && !ras_q)
                w[9*l +: 9] = dq_oe[9*l] ? dq_out[9*l +: 9] : 'x;
        end
        if (!row_strobe_n && !ras_q && !write_n)
            mem[{row_q, addr}] = w;
    end
    // data valid only after the access time
    always_comb
        for (int l = 0; l < 4; l++)
            shown[9*l +: 9] = (drv_q[l] && age_q >= 2) ?
                word_q[9*l +: 9] : ~word_q[9*l +: 9];
    assign #(slow_grade ? 20 : 10) dq_in = shown;
endmodule

// >>> dram_host_monitor.sv
// Purpose: Concurrent checks on the host's module pins.
// Assumes: Bound to dram_host; one clock domain.
// Notes:   Pause figure follows the host's own parameter.
module dram_host_monitor #(
    parameter int INIT_CYC = 8000,
    parameter int REFI_CYC = 390,
    parameter bit USE_CBR  = 1'b0
) (
    // Clock, reset, grade
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        slow_grade,
    // User side
    input wire logic        rsp_valid,
    input wire logic        init_done,
    // Module pins
    input wire logic        row_strobe_n,
    input wire logic [3:0]  col_strobe_n,
    input wire logic        write_n,
    input wire logic [35:0] dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [3:0] lane_oe;  // Lane fully driven
    int         up_cnt;   // Edges since reset
    // Lane drive summary
    always_comb
        for (int l = 0; l < 4; l++)
            lane_oe[l] = &dq_oe[9*l +: 9];
    // Time since reset release
    always_ff @(posedge ref_clk)
        up_cnt <= rst ? 0 : up_cnt + 1;
    // Column fall inside a row cycle
    sequence col_fall_s;
        (|($past(col_strobe_n) & ~col_strobe_n)) && !row_strobe_n;
    endsequence
    // Read answer within its window
    sequence answer_s;
        ##[1:8] rsp_valid;
    endsequence
    AST_STANDBY_FLOAT: assert property (row_strobe_n |-> dq_oe == 36'h0)
        else $error("bus driven in standby");
    AST_READ_QUIET: assert property (!row_strobe_n && write_n &&
        col_strobe_n != 4'hf |-> dq_oe == 36'h0)
        else $error("bus driven during read");
    AST_WRITE_DRIVES: assert property (!row_strobe_n && !write_n |->
        (~col_strobe_n & ~lane_oe) == 4'h0)
        else $error("strobed lane not driven on write");
    AST_READ_ANSWER: assert property (col_fall_s ##0 write_n |-> answer_s)
        else $error("read answer missing");
    AST_CBR_ORDER: assert property ($fell(row_strobe_n) &&
        col_strobe_n != 4'hf |-> write_n && $stable(col_strobe_n)
        ##1 col_strobe_n != 4'hf)
        else $error("column first refresh order broken");
    AST_RCD: assert property ($fell(row_strobe_n) &&
        $past(col_strobe_n) == 4'hf |-> col_strobe_n == 4'hf)
        else $error("column fell with row");
    AST_RAS_MIN: assert property ($fell(row_strobe_n) |->
        !row_strobe_n [*3])
        else $error("row pulse too short");
    AST_PRECHARGE: assert property ($rose(row_strobe_n) |->
        row_strobe_n [*2])
        else $error("row precharge too short");
    AST_CYCLE_SLOW: assert property (slow_grade && $fell(row_strobe_n)
        |=> !$fell(row_strobe_n) [*5])
        else $error("row cycle too short");
    AST_INIT_PAUSE: assert property ($fell(row_strobe_n) && !init_done
        |-> up_cnt >= INIT_CYC - 1)
        else $error("refresh before power-up pause");
    AST_INIT_KIND: assert property ($fell(row_strobe_n) && !init_done
        |-> (col_strobe_n != 4'hf) == USE_CBR)
        else $error("wrong power-up refresh kind");
endmodule
bind dram_host dram_host_monitor #(.INIT_CYC(INIT_CYC),
    .REFI_CYC(REFI_CYC), .USE_CBR(USE_CBR)) u_mon (.ref_clk(ref_clk),
    .rst(rst), .slow_grade(slow_grade), .rsp_valid(rsp_valid),
    .init_done(init_done), .row_strobe_n(row_strobe_n),
    .col_strobe_n(col_strobe_n), .write_n(write_n), .dq_oe(dq_oe));

// >>> fast_page_dram_module_access_tb.sv
// Purpose: Self-checking bench for the page mode host.
// Assumes: Module model on the pin side; short pause and refresh.
// Notes:   Power-up first, then table rows, refresh, page and reset cases.
module fast_page_dram_module_access_tb import dram_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct { req_t r; logic [35:0] exp; } row_t;
    logic        ref_clk, rst, slow_grade, req_valid, req_ready;
    logic        rsp_valid, init_done, row_strobe_n, write_n;
    logic [3:0]  col_strobe_n, presence_seen;
    logic [10:0] addr;
    logic [35:0] dq_out, dq_oe, dq_in;
    logic        pb1, pb2, pb3, pb4;
    req_t        req;
    rsp_t        rsp;
    int          fail_count, cmp_count, falls;
    // Ordinary cases: request beside expected read word
    row_t rows [9] = '{
        '{'{op_write, 11'h001, 11'h002, 4'hf, 1'b1, 36'h123456789}, 0},
        '{'{op_read, 11'h001, 11'h002, 4'hf, 1'b1, 36'h0}, 36'h123456789},
        '{'{op_write, 11'h7ff, 11'h7ff, 4'hf, 1'b1, 36'hfedcba987}, 0},
        '{'{op_read, 11'h7ff, 11'h7ff, 4'hf, 1'b1, 36'h0}, 36'hfedcba987},
        '{'{op_write, 11'h001, 11'h002, 4'h1, 1'b1, 36'hfffffffff}, 0},
        '{'{op_write, 11'h001, 11'h002, 4'h8, 1'b1, 36'h0}, 0},
        '{'{op_read, 11'h001, 11'h002, 4'hf, 1'b1, 36'h0}, 36'h0034567ff},
        '{'{op_refresh_row, 11'h003, 11'h0, 4'hf, 1'b1, 36'h0}, 0},
        '{'{op_refresh_cbr, 11'h0, 11'h0, 4'hf, 1'b1, 36'h0}, 0}};
    dram_host #(.INIT_CYC(20), .REFI_CYC(200), .USE_CBR(1'b0)) uut (
        .ref_clk(ref_clk), .rst(rst), .slow_grade(slow_grade),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp(rsp), .init_done(init_done),
        .presence_seen(presence_seen), .row_strobe_n(row_strobe_n),
        .col_strobe_n(col_strobe_n), .write_n(write_n), .addr(addr),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
        .presence_bit_one(pb1), .presence_bit_two(pb2),
        .presence_bit_three(pb3), .presence_bit_four(pb4));
    dram_module_model u_mod (.ref_clk(ref_clk), .slow_grade(slow_grade),
        .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
        .write_n(write_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe),
        .dq_in(dq_in), .presence_bit_one(pb1), .presence_bit_two(pb2),
        .presence_bit_three(pb3), .presence_bit_four(pb4));
    // Clock, 25 ns period
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Row cycles seen on the pins
    always @(negedge row_strobe_n) falls++;
    // Compare and count
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic end_of_test();
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // One request, held until taken
    task automatic send(input req_t r);
        int i;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req = r;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (req_ready !== 1'b1 && i < 400);
        if (req_ready !== 1'b1) begin
            fail_count++;
            end_of_test();
        end
        @(negedge ref_clk);
        req_valid = 1'b0;
    endtask
    // Wait for one read answer
    task automatic get(input logic [35:0] exp);
        for (int i = 0; i < 50 && rsp_valid !== 1'b1; i++) @(negedge ref_clk);
        if (rsp_valid !== 1'b1) begin
            fail_count++;
            end_of_test();
        end
        check(rsp.rdata, exp);
        // Step past the pulse so it is not taken twice
        @(negedge ref_clk);
    endtask
    // Power-up sequence and straps
    task automatic wait_init(input logic [3:0] straps);
        for (int i = 0; i < 400 && init_done !== 1'b1; i++)
            @(negedge ref_clk);
        check(36'(init_done), 36'h1);
        check(36'(falls), 36'd8);
        check(36'(presence_seen), 36'(straps));
        $display("Power-up test done");
    endtask
    initial begin
        rst = 1'b1;
        slow_grade = 1'b0;
        req_valid = 1'b0;
        req = '0;
        fail_count = 0;
        cmp_count = 0;
        falls = 0;
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        wait_init(4'he);
        // Table of single accesses and refreshes
        foreach (rows[i]) begin
            send(rows[i].r);
            if (rows[i].r.op == op_read) get(rows[i].exp);
        end
        $display("Table test done");
        // Periodic refresh while idle
        falls = 0;
        repeat (1000) @(negedge ref_clk);
        check(36'(falls >= 4 && falls <= 6), 36'h1);
        // Page write then page read, one row each, just after a refresh
        falls = 0;
        for (int i = 0; i < 400 && falls < 1; i++) @(negedge ref_clk);
        check(36'(falls), 36'd1);
        falls = 0;
        for (int k = 0; k < 4; k++)
            send('{op_write, 11'h055, 11'(k), 4'hf, k == 3, 36'h111 * (k + 1)});
        // Next column offered while the last answer is still due
        fork
            for (int k = 0; k < 4; k++)
                send('{op_read, 11'h055, 11'(k), 4'hf, k == 3, 36'h0});
            for (int k = 0; k < 4; k++)
                get(36'h111 * (k + 1));
        join
        check(36'(falls), 36'd2);
        $display("Page test done");
        // Reset in mid-run, slower grade afterwards
        @(negedge ref_clk);
        rst = 1'b1;
        slow_grade = 1'b1;
        repeat (6) @(negedge ref_clk);
        check(36'({row_strobe_n, col_strobe_n, req_ready}), 36'h3e);
        check(dq_oe, 36'h0);
        falls = 0;
        rst = 1'b0;
        wait_init(4'ha);
        send(rows[0].r);
        send(rows[1].r);
        get(rows[1].exp);
        $display("Reset and grade test done");
        end_of_test();
    end
endmodule
